//--- src/adc_port_map.svh
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// Timing figures and the clock they are counted in
`define MCLK_PERIOD_NS  25
`define CONVERT_STROBE_TIME_NS    3200
`define CONVERT_STROBE_CYCLES     (`CONVERT_STROBE_TIME_NS / `MCLK_PERIOD_NS)
`define LEAD_TIME_NS    60
`define LEAD_CYCLES     ((`LEAD_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CONVERT_STROBE_MARGIN     4
`define SCK_HALF        4

// Frame shape
`define RESULT_BITS     16
`define CONFIG_BITS     2
`define FRAME_SCKS      16

// Configuration word fields and values
`define CFG_SELECT_BIT  1
`define CFG_POLARITY_BIT 0
`define CFG_RESET       2'h2
`define MUX_ZERO_GND    2'h2
`define MUX_ONE_GND     2'h3
`define MUX_ZERO_ONE    2'h0
`define MUX_ONE_ZERO    2'h1

`endif

//--- src/adc_port_pkg.sv
package adc_port_pkg;

   // Device conversion sequencer states
   typedef enum logic [2:0]
   {
      ST_SAMPLE  = 3'b001,
      ST_CONVERT = 3'b010,
      ST_SLEEP   = 3'b100
   } dev_state_type;

   // Host transfer sequencer states
   typedef enum logic [4:0]
   {
      H_IDLE    = 5'b00001,
      H_LEAD    = 5'b00010,
      H_SHIFT   = 5'b00100,
      H_TAIL    = 5'b01000,
      H_CONVERT = 5'b10000
   } host_state_type;

   // Input pairing chosen by the configuration word
   typedef enum logic [3:0]
   {
      PAIR_ZERO_GND = 4'b0001,
      PAIR_ONE_GND  = 4'b0010,
      PAIR_ZERO_ONE = 4'b0100,
      PAIR_ONE_ZERO = 4'b1000
   } pairing_type;

endpackage : adc_port_pkg

//--- src/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
   logic sck;                // Shift clock from the host
   logic convert_strobe;     // Convert strobe from the host
   logic serial_config_in;   // Configuration bit from the host
   logic serial_result_out;  // Result bit from the device
   logic serial_result_oe;   // Device drives the result line
   logic result_line;        // Resolved result wire level

   // Released line has no pull: it shows the inverse, so a late enable is caught
   assign result_line = serial_result_oe ? serial_result_out : !serial_result_out;

   modport device
   (
      input  sck,
      input  convert_strobe,
      input  serial_config_in,
      output serial_result_out,
      output serial_result_oe
   );

   modport host
   (
      output sck,
      output convert_strobe,
      output serial_config_in,
      input  result_line
   );
endinterface : adc_link_if

//--- src/sync_level.sv
`timescale 1ns/1ps
module sync_level
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             mclk,   // Destination clock
   input  wire logic             rstn,   // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] async_in, // Level from another domain
   output logic      [WIDTH-1:0] sync_out  // Level after two flops
);
   typedef struct packed
   {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_type;

   sync_type r;
   sync_type next_r;

   // Two-stage chain; the first stage feeds only the second
   always_comb
   begin
      next_r        = r;
      next_r.first  = async_in;
      next_r.second = r.first;
      if (!rstn)
      begin
         next_r = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      r <= next_r;
   end

   assign sync_out = r.second;
endmodule : sync_level

//--- src/adc_device.sv
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_device
   import adc_port_pkg::*;
#(
   parameter int TWO_CHANNEL = 1,            // Configuration word is accepted
   parameter int CONVERT_STROBE_CYCLES = `CONVERT_STROBE_CYCLES  // Conversion length in mclk cycles
)
(
   input  wire logic        mclk,            // Internal conversion clock
   input  wire logic        rstn,            // Synchronous reset, active low
   adc_link_if.device       link,            // Four-wire serial port
   input  wire logic [15:0] sample_code,     // Code from the converter core
   output logic             sample_now,      // Pulse: hold the analog input
   output logic             conversion_busy, // Conversion in progress
   output logic             sleeping,        // Powered-down after conversion
   output logic [1:0]       mux_config,      // Select and polarity in use
   output pairing_type      input_pairing    // Decoded input pairing
);

   // Conversion side state, clocked by mclk
   typedef struct packed
   {
      dev_state_type state;
      logic [15:0]   timer;
      logic          strobe_prev;
      logic [15:0]   result_hold;
      logic [1:0]    mux_config;
      pairing_type   pairing;
      logic          oe;
      logic          sample_now;
      logic          busy;
      logic          sleeping;
      logic [1:0]    settle;
   } convert_strobe_type;

   // Transmit side state, clocked by falling shift clock
   typedef struct packed
   {
      logic [4:0] bit_count;
   } tx_type;

   // Receive side state, clocked by rising shift clock
   typedef struct packed
   {
      logic [1:0] cfg_count;
      logic [1:0] cfg_word;
   } rx_type;

   convert_strobe_type r;
   convert_strobe_type next_r;
   tx_type   tx;
   tx_type   next_tx;
   rx_type   rx;
   rx_type   next_rx;
   logic     strobe_s;

   // Pick the bit at a given position, zero once the word is used up
   function automatic logic pick_bit(input logic [15:0] word, input logic [4:0] count);
      logic result;
      result = 1'b0;
      if (count < 5'(`RESULT_BITS))
      begin
         result = word[4'(5'(`RESULT_BITS - 1) - count)];
      end
      return result;
   endfunction : pick_bit

   // Translate select and polarity into the input pairing
   function automatic pairing_type decode_pairing(input logic [1:0] cfg);
      pairing_type result;
      case (cfg)
         `MUX_ZERO_GND: result = PAIR_ZERO_GND;
         `MUX_ONE_GND:  result = PAIR_ONE_GND;
         `MUX_ZERO_ONE: result = PAIR_ZERO_ONE;
         `MUX_ONE_ZERO: result = PAIR_ONE_ZERO;
         default:       result = PAIR_ZERO_GND;
      endcase
      return result;
   endfunction : decode_pairing

   // Strobe pin into the conversion clock domain
   sync_level #(.WIDTH(1)) strobe_sync
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .async_in (link.convert_strobe),
      .sync_out (strobe_s)
   );

   // Conversion sequencer: sample, convert, then sleep or return to sample
   always_comb
   begin
      next_r             = r;
      next_r.strobe_prev = strobe_s;
      next_r.sample_now  = 1'b0;
      next_r.oe          = !strobe_s;
      next_r.settle      = {r.settle[0], 1'b1};
      case (r.state)
         ST_SAMPLE:
         begin
            if (strobe_s && !r.strobe_prev)
            begin
               next_r.state      = ST_CONVERT;
               next_r.timer      = '0;
               next_r.sample_now = 1'b1;
               next_r.busy       = 1'b1;
               // Word captured in the frame just ended steers this conversion
               if (TWO_CHANNEL != 0)
               begin
                  next_r.mux_config = rx.cfg_word;
               end
               else
               begin
                  next_r.mux_config = `CFG_RESET;
               end
               next_r.pairing = decode_pairing(next_r.mux_config);
            end
         end
         ST_CONVERT:
         begin
            next_r.timer = r.timer + 16'h0001;
            if (r.timer == 16'(CONVERT_STROBE_CYCLES - 1))
            begin
               next_r.result_hold = sample_code;
               next_r.busy        = 1'b0;
               if (strobe_s)
               begin
                  next_r.state    = ST_SLEEP;
                  next_r.sleeping = 1'b1;
               end
               else
               begin
                  next_r.state = ST_SAMPLE;
               end
            end
         end
         ST_SLEEP:
         begin
            if (!strobe_s)
            begin
               next_r.state    = ST_SAMPLE;
               next_r.sleeping = 1'b0;
            end
         end
         default:
         begin
            next_r.state = ST_SAMPLE;
         end
      endcase
      // Synchroniser still shows its reset zero: keep the line off, block a false start
      if (!r.settle[1])
      begin
         next_r.oe          = 1'b0;
         next_r.strobe_prev = 1'b1;
      end
      if (!rstn)
      begin
         next_r            = '0;
         next_r.state      = ST_SAMPLE;
         next_r.mux_config = `CFG_RESET;
         next_r.pairing    = PAIR_ZERO_GND;
         next_r.strobe_prev = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      r <= next_r;
   end

   // Bit position advances on each falling shift clock, stops past the word
   always_comb
   begin
      next_tx = tx;
      if (tx.bit_count < 5'(`RESULT_BITS))
      begin
         next_tx.bit_count = tx.bit_count + 5'h01;
      end
   end

   // A high strobe rewinds the frame even while the shift clock stands still
   always_ff @(negedge link.sck or posedge link.convert_strobe)
   begin
      if (link.convert_strobe)
      begin
         tx <= '0;
      end
      else
      begin
         tx <= next_tx;
      end
   end

   // Configuration capture on rising shift clock, first two bits only
   always_comb
   begin
      next_rx = rx;
      if ((TWO_CHANNEL != 0) && (rx.cfg_count < 2'(`CONFIG_BITS)))
      begin
         next_rx.cfg_word  = {rx.cfg_word[0], link.serial_config_in};
         next_rx.cfg_count = rx.cfg_count + 2'h1;
      end
   end

   // Strobe high rewinds only the count; the word stays for the next start
   always_ff @(posedge link.sck or posedge link.convert_strobe)
   begin
      if (link.convert_strobe)
      begin
         rx.cfg_count <= '0;
      end
      else
      begin
         rx <= next_rx;
      end
   end

   // Result word is quasi-static while the strobe is low, so the link reads it directly
   assign link.serial_result_out = pick_bit(r.result_hold, tx.bit_count);
   assign link.serial_result_oe  = r.oe;

   // User-side outputs
   assign sample_now      = r.sample_now;
   assign conversion_busy = r.busy;
   assign sleeping        = r.sleeping;
   assign mux_config      = r.mux_config;
   assign input_pairing   = r.pairing;
endmodule : adc_device

//--- src/adc_host.sv
`timescale 1ns/1ps
`include "adc_port_map.svh"
module adc_host
   import adc_port_pkg::*;
#(
   parameter int SCK_HALF    = `SCK_HALF,                      // Half shift clock period in mclk
   parameter int CONVERT_STROBE_WAIT   = `CONVERT_STROBE_CYCLES + `CONVERT_STROBE_MARGIN,    // Strobe high time in mclk
   parameter int LEAD_CYCLES = `LEAD_CYCLES                    // Strobe low before first rise
)
(
   input  wire logic        mclk,         // Host clock
   input  wire logic        rstn,         // Synchronous reset, active low
   adc_link_if.host         link,         // Four-wire serial port
   input  wire logic        start,        // Pulse: run one frame and conversion
   input  wire logic [1:0]  config_word,  // Select and polarity for next conversion
   output logic             busy,         // Frame or conversion under way
   output logic [15:0]      result,       // Word read in the last frame
   output logic             result_valid  // Pulse: result updated
);

   typedef struct packed
   {
      host_state_type state;
      logic [15:0]    cnt;
      logic [7:0]     phase;
      logic [4:0]     bits;
      logic           sck;
      logic           strobe;
      logic           cfg_out;
      logic [1:0]     cfg_shift;
      logic [15:0]    rx;
      logic [15:0]    result;
      logic           result_valid;
      logic           busy;
   } host_type;

   host_type r;
   host_type next_r;
   logic     line_s;

   // Result line into the host clock domain
   sync_level #(.WIDTH(1)) line_sync
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .async_in (link.result_line),
      .sync_out (line_s)
   );

   // Frame sequencer: strobe low, sixteen shift clocks, strobe high for conversion
   always_comb
   begin
      next_r              = r;
      next_r.result_valid = 1'b0;
      case (r.state)
         H_IDLE:
         begin
            if (start)
            begin
               next_r.state     = H_LEAD;
               next_r.strobe    = 1'b0;
               next_r.cfg_shift = config_word;
               next_r.cfg_out   = config_word[`CFG_SELECT_BIT];
               next_r.cnt       = '0;
               next_r.busy      = 1'b1;
            end
         end
         H_LEAD:
         begin
            next_r.cnt = r.cnt + 16'h0001;
            if (r.cnt == 16'(LEAD_CYCLES - 1))
            begin
               next_r.state = H_SHIFT;
               next_r.sck   = 1'b1;
               next_r.phase = '0;
               next_r.bits  = '0;
            end
         end
         H_SHIFT:
         begin
            next_r.phase = r.phase + 8'h01;
            // Sample late in the high half, well after the synchroniser settles
            if (r.sck && (r.phase == 8'h02))
            begin
               next_r.rx = {r.rx[14:0], line_s};
            end
            if (r.phase == 8'(SCK_HALF - 1))
            begin
               next_r.phase = '0;
               next_r.sck   = !r.sck;
               if (r.sck)
               begin
                  next_r.cfg_shift = {r.cfg_shift[0], 1'b0};
                  next_r.cfg_out   = r.cfg_shift[0];
                  next_r.bits      = r.bits + 5'h01;
                  if (r.bits == 5'(`FRAME_SCKS - 1))
                  begin
                     next_r.state = H_TAIL;
                     next_r.sck   = 1'b0;
                     next_r.cnt   = '0;
                  end
               end
            end
         end
         H_TAIL:
         begin
            next_r.state  = H_CONVERT;
            next_r.strobe = 1'b1;
            next_r.cnt    = '0;
         end
         H_CONVERT:
         begin
            next_r.cnt = r.cnt + 16'h0001;
            if (r.cnt == 16'(CONVERT_STROBE_WAIT - 1))
            begin
               next_r.state        = H_IDLE;
               next_r.result       = r.rx;
               next_r.result_valid = 1'b1;
               next_r.busy         = 1'b0;
            end
         end
         default:
         begin
            next_r.state = H_IDLE;
         end
      endcase
      if (!rstn)
      begin
         next_r        = '0;
         next_r.state  = H_IDLE;
         next_r.strobe = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      r <= next_r;
   end

   assign link.sck              = r.sck;
   assign link.convert_strobe   = r.strobe;
   assign link.serial_config_in = r.cfg_out;
   assign busy                  = r.busy;
   assign result                = r.result;
   assign result_valid          = r.result_valid;
endmodule : adc_host

//--- verif/adc_link_monitor.sv
`timescale 1ns/1ps
module adc_link_monitor
#(
   parameter int CONVERT_STROBE_CYCLES = 8  // Conversion length in device clocks
)
(
   input wire logic mclk,              // Device clock
   input wire logic rstn,              // Reset, active low
   input wire logic sck,               // Shift clock
   input wire logic convert_strobe,    // Convert strobe
   input wire logic serial_result_out, // Result bit
   input wire logic serial_result_oe   // Result drive enable
);
   logic [15:0] rise_cnt;
   logic [15:0] fall_cnt;
   logic [15:0] hi_cnt;

   // Shift clock edges inside a frame and strobe high time
   always_ff @(posedge mclk)
   begin
      if (!rstn || convert_strobe)
      begin
         rise_cnt <= '0;
         fall_cnt <= '0;
      end
      else
      begin
         rise_cnt <= rise_cnt + 16'($rose(sck));
         fall_cnt <= fall_cnt + 16'($fell(sck));
      end
      hi_cnt <= (!rstn || !convert_strobe) ? '0 : hi_cnt + 16'(hi_cnt != 16'hffff);
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_held_high;
      convert_strobe [*5];
   endsequence
   sequence s_held_low;
      !convert_strobe [*5];
   endsequence

   property p_release;
      $rose(convert_strobe) |-> ##[1:5] !serial_result_oe;
   endproperty
   property p_stays_off;
      s_held_high |-> !serial_result_oe;
   endproperty
   property p_enable;
      $fell(convert_strobe) |-> ##[1:5] serial_result_oe;
   endproperty
   property p_drive_hold;
      s_held_low |-> serial_result_oe;
   endproperty
   property p_shift_edge;
      serial_result_oe && $past(serial_result_oe) && !convert_strobe && $changed(serial_result_out) |-> $fell(sck);
   endproperty
   property p_zero_tail;
      fall_cnt >= 16 && serial_result_oe && !convert_strobe |-> !serial_result_out;
   endproperty
   property p_transfer_len;
      $rose(convert_strobe) |-> rise_cnt >= 16;
   endproperty
   property p_convert_strobe_hold;
      $fell(convert_strobe) |-> hi_cnt >= CONVERT_STROBE_CYCLES + 3;
   endproperty
   property p_sck_framed;
      sck |-> !convert_strobe;
   endproperty

   a_release      : assert property (p_release) else $error("result line still driven after strobe rise");
   a_stays_off    : assert property (p_stays_off) else $error("result line driven during conversion");
   a_enable       : assert property (p_enable) else $error("result line not enabled after strobe fall");
   a_drive_hold   : assert property (p_drive_hold) else $error("result line released while strobe low");
   a_shift_edge   : assert property (p_shift_edge) else $error("result bit changed away from a falling edge");
   a_zero_tail    : assert property (p_zero_tail) else $error("nonzero bit after the result word");
   a_transfer_len : assert property (p_transfer_len) else $error("frame ended with too few shift clocks");
   a_convert_strobe_hold    : assert property (p_convert_strobe_hold) else $error("strobe lowered before conversion time");
   a_sck_framed   : assert property (p_sck_framed) else $error("shift clock high outside a frame");
endmodule : adc_link_monitor

//--- verif/serial_adc_conversion_port_tb_top.sv
`timescale 1ns/1ps
module serial_adc_conversion_port_tb_top;
   import adc_port_pkg::*;
   localparam int CONVERT_STROBE = 8;
   logic        mclk, dclk, rstn, start, busy, result_valid, sleep2, busy2, sample2;
   int          samples;
   logic [1:0]  config_word, mux_config, mux2;
   logic [15:0] code, code2, result, word, word2;
   pairing_type pairing;
   int          num_errors, compares, rises, n;
   logic [15:0] codes [5] = '{16'hffff, 16'h0001, 16'ha55a, 16'h8000, 16'h7ffe};
   pairing_type pexp [4] = '{PAIR_ZERO_ONE, PAIR_ONE_ZERO, PAIR_ZERO_GND, PAIR_ONE_GND};

   adc_link_if link ();
   adc_link_if link2 ();

   adc_host #(.CONVERT_STROBE_WAIT(CONVERT_STROBE + 4)) u_adc_host (.mclk(mclk), .rstn(rstn), .link(link), .start(start),
      .config_word(config_word), .busy(busy), .result(result), .result_valid(result_valid));
   adc_device #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE)) u_adc_device (.mclk(dclk), .rstn(rstn), .link(link), .sample_code(code),
      .sample_now(), .conversion_busy(), .sleeping(), .mux_config(mux_config), .input_pairing(pairing));
   adc_device #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE)) u_adc_device_2 (.mclk(dclk), .rstn(rstn), .link(link2), .sample_code(code2),
      .sample_now(sample2), .conversion_busy(busy2), .sleeping(sleep2), .mux_config(mux2), .input_pairing());
   adc_link_monitor #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE)) u_adc_link_monitor (.mclk(dclk), .rstn(rstn), .sck(link.sck),
      .convert_strobe(link.convert_strobe), .serial_result_out(link.serial_result_out),
      .serial_result_oe(link.serial_result_oe));

   // Host clock and unrelated device clock
   initial
   begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end

   initial
   begin
      dclk = 0;
      #3.1;
      forever #7.5 dclk = ~dclk;
   end

   // Count conversion starts on the second device, away from the launching edge
   always @(negedge dclk)
   begin
      if (sample2 === 1'b1)
      begin
         samples++;
      end
   end

   // Collect the wire bits the host end sees
   always @(posedge link.sck)
   begin
      if (link.convert_strobe === 1'b0)
      begin
         word = {word[14:0], link.result_line};
         rises++;
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // Testbench plays the host on the second link, shifting n clocks
   task automatic frame2(input logic [1:0] cfg, input int nclk);
      @(posedge mclk) #2 link2.convert_strobe = 0;
      link2.serial_config_in = cfg[1];
      repeat (4) @(posedge mclk);
      for (int k = 0; k < nclk; k++)
      begin
         @(posedge mclk) #2 link2.sck = 1;
         if (k < 16) word2 = {word2[14:0], link2.result_line};
         else check(16'(link2.result_line), 16'h0, "tail bit");
         repeat (4) @(posedge mclk);
         #2 link2.sck = 0;
         link2.serial_config_in = (k == 0) ? cfg[0] : ~cfg[k % 2];
         repeat (3) @(posedge mclk);
      end
      @(posedge mclk) #2 link2.convert_strobe = 1;
   endtask : frame2

   // Wait out a conversion on the second device
   task automatic convert_strobe_wait();
      repeat (CONVERT_STROBE + 6) @(posedge dclk);
      #2;
   endtask : convert_strobe_wait

   // Watchdog
   initial
   begin
      #200000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      rstn = 0; start = 0; config_word = 0; code = 0; code2 = 0; word = 0; word2 = 0;
      link2.sck = 0; link2.convert_strobe = 1; link2.serial_config_in = 0;
      num_errors = 0; compares = 0; rises = 0; samples = 0;
      repeat (10) @(posedge mclk);
      #2 rstn = 1;
      repeat (20) @(posedge mclk);
      // Back-to-back frames through both ends, every input pairing
      for (int i = 0; i < 5; i++)
      begin
         @(posedge mclk) #2 code = codes[i];
         config_word = 2'(i);
         start = 1;
         rises = 0;
         @(posedge mclk) #2 start = 0;
         check(16'(busy), 16'h1, "busy in frame");
         n = 0;
         do begin @(posedge mclk); #1; n++; end while (result_valid !== 1'b1 && n < 400);
         check(16'(result_valid), 16'h1, "completion");
         check(16'(busy), 16'h0, "busy cleared");
         check(result, (i > 0) ? codes[i-1] : 16'h0, "result word");
         check(word, (i > 0) ? codes[i-1] : 16'h0, "wire bits");
         check(16'(rises), 16'd16, "shift clocks");
         check(16'(mux_config), 16'(i % 4), "mux config");
         check(16'(pairing), 16'(pexp[i % 4]), "pairing");
      end
      // Second device: sleep, extra config bits, zero tail, early strobe fall
      #2 code2 = 16'h3c5a;
      frame2(2'h3, 16);
      convert_strobe_wait();
      check(16'(sleep2), 16'h1, "sleep");
      check(16'(samples), 16'd1, "one start");
      check(16'(link2.serial_result_oe), 16'h0, "line released");
      check(16'(mux2), 16'h3, "config two bits");
      frame2(2'h1, 20);
      check(word2, 16'h3c5a, "msb first");
      convert_strobe_wait();
      check(16'(mux2), 16'h1, "extra bits ignored");
      check(16'(samples), 16'd2, "two starts");
      // Wake from sleep, then lower the strobe again before the conversion ends
      link2.convert_strobe = 0;
      convert_strobe_wait();
      check(16'(sleep2), 16'h0, "wake on strobe low");
      check(16'(link2.serial_result_oe), 16'h1, "line driven");
      link2.convert_strobe = 1;
      repeat (5) @(posedge dclk);
      #2 link2.convert_strobe = 0;
      convert_strobe_wait();
      check(16'(sleep2), 16'h0, "no sleep when low");
      check(16'(busy2), 16'h0, "conversion finished");
      check(16'(samples), 16'd3, "third start");
      check(16'(link2.serial_result_oe), 16'h1, "line driven again");
      link2.convert_strobe = 1;
      convert_strobe_wait();
      wrap_up();
   end
endmodule : serial_adc_conversion_port_tb_top
